// ===== rtl/pcfd_ctrl_flags.sv
// Processor control flag registers and their feature decode.
// Assumes one synchronous clock, all inputs synchronous to it, and
// the instruction front end presenting one-cycle request pulses.
//
// Summary of operation
// RQ1: FP instruction waits for previous completion
// RQ2: Reset clears extension control register
// RQ3: Emulation flag traps FP, else dispatch
// RQ4: Monitor flag makes waits test switch
// RQ5: Emulation without monitor gives vector seven
// RQ6: Bit ten flags SIMD exception support
// RQ7: Bit nine flags FP state save
// RQ8: Bit five widens physical addresses
// RQ9: Bit seven keeps global entries on flush
// RQ10: Bit eight allows counter reads everywhere
// RQ11: Two virtual interrupt enables
// RQ12: Timestamp read restricted to level zero
// RQ13: Debug extension faults regs four, five
// RQ14: Large page enable for 32-bit paging
// RQ15: Machine check only when enabled
// RQ16: Numeric error reported internally when set
// RQ17: Write protect blocks supervisor writes
// RQ18: Alignment checked when both flags set
// RQ19: Cache off and write-through suppression
// RQ20: Cache-off pin from page base unpaged
// RQ21: Write-through pin from page base unpaged
// RQ22: Control word after init shows FPU presence
// RQ23: Undefined extension bits read zero
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module pcfd_ctrl_flags (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [1:0]  cpl,
   input  wire logic        fp_issue,
   input  wire logic        fpu_done,
   input  wire logic        fpu_present,
   input  wire logic        fp_wait_instr,
   input  wire logic        fp_init_instr,
   input  wire logic        fp_numeric_err,
   input  wire logic        read_perf_counter_instr,
   input  wire logic        read_timestamp_instr,
   input  wire logic        dbg_access,
   input  wire logic [2:0]  dbg_idx,
   input  wire logic        hw_error,
   input  wire logic        align_check_flag,
   input  wire logic        bus_cycle,
   input  wire logic        bus_unpaged,
   input  wire logic        pte_cache_off,
   input  wire logic        pte_write_thru,
   output logic             fp_stall,
   output logic             fp_dispatch_q,
   output logic             dev_not_avail_q,
   output logic      [7:0]  exc_vector_q,
   output logic             wait_done_q,
   output logic      [15:0] fp_ctrl_word_q,
   output logic             fp_err_internal_q,
   output logic             fp_err_external_q,
   output logic             perf_read_ok_q,
   output logic             timestamp_read_ok_q,
   output logic             priv_fault_q,
   output logic             undefined_opcode_fault_q,
   output logic      [2:0]  dbg_idx_eff_q,
   output logic             machine_check_q,
   output logic             tlb_flush_q,
   output logic             tlb_keep_global_q,
   output logic             phys_addr_wide,
   output logic             large_page_en,
   output logic             v86_virq_en,
   output logic             pm_virq_en,
   output logic             simd_fp_exception_support,
   output logic             fp_state_save_support,
   output logic             sup_write_protect,
   output logic             align_check_active,
   output logic             cache_en,
   output logic             wt_inval_en,
   output logic             cache_off_pin_q,
   output logic             write_thru_pin_q
);
   logic [31:0] mc_q;
   logic [31:0] pb_q;
   logic [31:0] ec_q;
   logic        fp_busy_q;
   logic        software_fp_trap;
   logic        wait_test_switch_enable;
   logic        fpu_ctx_switched;
   logic        switch_test_hit;
   logic        dev_na_event;
   logic        kernel;
   logic        fp_accept;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mc_q <= pcfd_pkg::MC_RESET;
      end else if (reg_wr && reg_addr == pcfd_pkg::ADDR_MACHINE_CONTROL) begin
         mc_q <= reg_wdata & pcfd_pkg::MC_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pb_q <= pcfd_pkg::PB_RESET;
      end else if (reg_wr && reg_addr == pcfd_pkg::ADDR_PAGE_BASE_CONTROL) begin
         pb_q <= reg_wdata & pcfd_pkg::PB_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ec_q <= pcfd_pkg::EC_RESET; // RQ2
      end else if (reg_wr && reg_addr == pcfd_pkg::ADDR_EXTENSION_CONTROL) begin
         ec_q <= reg_wdata & pcfd_pkg::EC_WRITE_MASK; // RQ23
      end
   end

   // ****************************************************************
   // Register reads, data valid the cycle after the strobe
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            pcfd_pkg::ADDR_MACHINE_CONTROL:   reg_rdata <= mc_q;
            pcfd_pkg::ADDR_PAGE_BASE_CONTROL: reg_rdata <= pb_q;
            pcfd_pkg::ADDR_EXTENSION_CONTROL: reg_rdata <= ec_q; // RQ23
            pcfd_pkg::ADDR_STATUS: begin
               reg_rdata <= {fp_ctrl_word_q, 15'h0000, fp_busy_q};
            end
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Floating-point dispatch, trapping and synchronisation
   // ****************************************************************
   assign software_fp_trap        = mc_q[pcfd_pkg::MC_SOFTWARE_FP_TRAP];
   assign wait_test_switch_enable = mc_q[pcfd_pkg::MC_WAIT_TEST_SWITCH_ENABLE];
   assign fpu_ctx_switched        = mc_q[pcfd_pkg::MC_FPU_CTX_SWITCHED];
   assign kernel                  = (cpl == pcfd_pkg::CPL_KERNEL);
   // Held off while the previous instruction is still running
   assign fp_stall  = fp_issue && !software_fp_trap && fp_busy_q; // RQ1
   assign fp_accept = fp_issue && !software_fp_trap && !fp_busy_q;
   // Waiting ops look at the switch flag only with the monitor flag set
   assign switch_test_hit = fp_wait_instr && wait_test_switch_enable
                            && fpu_ctx_switched; // RQ4
   assign dev_na_event    = (fp_issue && software_fp_trap) || switch_test_hit; // RQ3 RQ5

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_busy_q <= 1'b0;
      end else if (fp_accept) begin
         fp_busy_q <= 1'b1; // RQ1
      end else if (fpu_done) begin
         fp_busy_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_dispatch_q   <= 1'b0;
         dev_not_avail_q <= 1'b0;
         exc_vector_q    <= 8'h00;
         wait_done_q     <= 1'b0;
      end else begin
         fp_dispatch_q   <= fp_accept; // RQ3
         // Emulation traps every FP op; a waiting op traps on a switch while the monitor flag is set
         dev_not_avail_q <= dev_na_event; // RQ3 RQ4 RQ5
         exc_vector_q    <= dev_na_event ? pcfd_pkg::DEV_NOT_AVAIL_VEC : 8'h00; // RQ5
         wait_done_q     <= fp_wait_instr && !switch_test_hit; // RQ4
      end
   end

   // ****************************************************************
   // Control word after initialisation and numeric errors
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_ctrl_word_q <= pcfd_pkg::FP_CW_ABSENT;
      end else if (fp_init_instr) begin
         fp_ctrl_word_q <= fpu_present ? pcfd_pkg::FP_CW_PRESENT
                                       : pcfd_pkg::FP_CW_ABSENT; // RQ22
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_err_internal_q <= 1'b0;
         fp_err_external_q <= 1'b0;
      end else begin
         fp_err_internal_q <= fp_numeric_err && mc_q[pcfd_pkg::MC_NUMERIC_ERROR_REPORT]; // RQ16
         fp_err_external_q <= fp_numeric_err && !mc_q[pcfd_pkg::MC_NUMERIC_ERROR_REPORT];
      end
   end

   // ****************************************************************
   // Privileged reads, debug aliasing and machine check
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         perf_read_ok_q      <= 1'b0;
         timestamp_read_ok_q <= 1'b0;
         priv_fault_q        <= 1'b0;
      end else begin
         perf_read_ok_q <= read_perf_counter_instr
                           && (kernel || ec_q[pcfd_pkg::EC_PERF_COUNTER_USER_EN]); // RQ10
         timestamp_read_ok_q <= read_timestamp_instr
                                && (kernel || !ec_q[pcfd_pkg::EC_TIMESTAMP_RESTRICT]); // RQ12
         priv_fault_q <= (read_perf_counter_instr && !kernel
                          && !ec_q[pcfd_pkg::EC_PERF_COUNTER_USER_EN])
                         || (read_timestamp_instr && !kernel
                          && ec_q[pcfd_pkg::EC_TIMESTAMP_RESTRICT]); // RQ12
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         undefined_opcode_fault_q <= 1'b0;
         dbg_idx_eff_q            <= 3'h0;
      end else begin
         undefined_opcode_fault_q <= dbg_access && ec_q[pcfd_pkg::EC_DBG_EXTENSIONS]
                                     && (dbg_idx == pcfd_pkg::DBG_IDX_FOUR
                                      || dbg_idx == pcfd_pkg::DBG_IDX_FIVE); // RQ13
         // Without the extension, four and five alias six and seven
         if (!ec_q[pcfd_pkg::EC_DBG_EXTENSIONS]
             && (dbg_idx == pcfd_pkg::DBG_IDX_FOUR || dbg_idx == pcfd_pkg::DBG_IDX_FIVE)) begin
            dbg_idx_eff_q <= 3'(dbg_idx + pcfd_pkg::DBG_ALIAS_OFFSET); // RQ13
         end else begin
            dbg_idx_eff_q <= dbg_idx;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         machine_check_q <= 1'b0;
      end else begin
         machine_check_q <= hw_error && ec_q[pcfd_pkg::EC_MACHINE_CHECK_ENABLE]; // RQ15
      end
   end

   // ****************************************************************
   // Translation flush on page base writes
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tlb_flush_q       <= 1'b0;
         tlb_keep_global_q <= 1'b0;
      end else begin
         tlb_flush_q       <= reg_wr && reg_addr == pcfd_pkg::ADDR_PAGE_BASE_CONTROL;
         tlb_keep_global_q <= reg_wr && reg_addr == pcfd_pkg::ADDR_PAGE_BASE_CONTROL
                              && ec_q[pcfd_pkg::EC_GLOBAL_PAGE_ENABLE]; // RQ9
      end
   end

   // ****************************************************************
   // Feature enables
   // ****************************************************************
   assign phys_addr_wide            = ec_q[pcfd_pkg::EC_PHYS_ADDR_EXTENSION]; // RQ8
   assign large_page_en             = ec_q[pcfd_pkg::EC_LARGE_PAGE_ENABLE]; // RQ14
   assign v86_virq_en               = ec_q[pcfd_pkg::EC_V86_EXTENSIONS]; // RQ11
   assign pm_virq_en                = ec_q[pcfd_pkg::EC_PROTECTED_VIRTUAL_IRQ]; // RQ11
   assign simd_fp_exception_support = ec_q[pcfd_pkg::EC_SIMD_FP_EXC_SUPPORT]; // RQ6
   assign fp_state_save_support     = ec_q[pcfd_pkg::EC_FP_STATE_SAVE_SUPPORT]; // RQ7
   assign sup_write_protect         = mc_q[pcfd_pkg::MC_WRITE_PROTECT]; // RQ17
   assign align_check_active        = mc_q[pcfd_pkg::MC_ALIGNMENT_GATE]
                                      && align_check_flag; // RQ18
   assign cache_en                  = !mc_q[pcfd_pkg::MC_CACHE_OFF]; // RQ19
   assign wt_inval_en               = !mc_q[pcfd_pkg::MC_NO_WRITE_THROUGH]; // RQ19

   // ****************************************************************
   // Page attribute pins toward the external cache
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cache_off_pin_q  <= 1'b0;
         write_thru_pin_q <= 1'b0;
      end else if (bus_cycle && mc_q[pcfd_pkg::MC_PAGING_ENABLE] && bus_unpaged) begin
         cache_off_pin_q  <= pb_q[pcfd_pkg::PB_PAGE_LEVEL_CACHE_OFF]; // RQ20
         write_thru_pin_q <= pb_q[pcfd_pkg::PB_PAGE_LEVEL_WRITE_THRU]; // RQ21
      end else if (bus_cycle && mc_q[pcfd_pkg::MC_PAGING_ENABLE]) begin
         cache_off_pin_q  <= pte_cache_off;
         write_thru_pin_q <= pte_write_thru;
      end else begin
         cache_off_pin_q  <= 1'b0;
         write_thru_pin_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_ec_reset;
      @(posedge sys_clk) rst |=> ec_q == 32'h0000_0000;
   endproperty
   a_ec_reset: assert property (p_ec_reset) else $error("ext ctrl not cleared"); // RQ2

   property p_no_overlap;
      @(posedge sys_clk) disable iff (rst)
      fp_issue && fp_busy_q |=> !fp_dispatch_q;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("fp overlap"); // RQ1

   property p_trap;
      @(posedge sys_clk) disable iff (rst)
      fp_issue && software_fp_trap |=> dev_not_avail_q && !fp_dispatch_q;
   endproperty
   a_trap: assert property (p_trap) else $error("emulation trap missing"); // RQ3

   property p_vec7;
      @(posedge sys_clk) disable iff (rst)
      fp_issue && software_fp_trap && !wait_test_switch_enable
      |=> exc_vector_q == pcfd_pkg::DEV_NOT_AVAIL_VEC;
   endproperty
   a_vec7: assert property (p_vec7) else $error("bad vector"); // RQ5

   property p_wait_ts;
      @(posedge sys_clk) disable iff (rst)
      fp_wait_instr && !wait_test_switch_enable |=> wait_done_q;
   endproperty
   a_wait_ts: assert property (p_wait_ts) else $error("wait tested switch"); // RQ4

   property p_ts_restrict;
      @(posedge sys_clk) disable iff (rst)
      read_timestamp_instr && cpl != 2'h0 && ec_q[pcfd_pkg::EC_TIMESTAMP_RESTRICT]
      |=> priv_fault_q && !timestamp_read_ok_q;
   endproperty
   a_ts_restrict: assert property (p_ts_restrict) else $error("timestamp not faulted"); // RQ12

   property p_dbg;
      @(posedge sys_clk) disable iff (rst)
      dbg_access && dbg_idx == 3'h5 && ec_q[pcfd_pkg::EC_DBG_EXTENSIONS]
      |=> undefined_opcode_fault_q;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug five not faulted"); // RQ13

   property p_mc_gate;
      @(posedge sys_clk) disable iff (rst)
      machine_check_q |-> $past(ec_q[pcfd_pkg::EC_MACHINE_CHECK_ENABLE]);
   endproperty
   a_mc_gate: assert property (p_mc_gate) else $error("machine check ungated"); // RQ15

   property p_cw;
      @(posedge sys_clk) disable iff (rst)
      fp_init_instr && fpu_present |=> fp_ctrl_word_q == 16'h037f;
   endproperty
   a_cw: assert property (p_cw) else $error("bad control word"); // RQ22

   property p_pin;
      @(posedge sys_clk) disable iff (rst)
      bus_cycle && bus_unpaged && mc_q[pcfd_pkg::MC_PAGING_ENABLE]
      |=> cache_off_pin_q == $past(pb_q[pcfd_pkg::PB_PAGE_LEVEL_CACHE_OFF]);
   endproperty
   a_pin: assert property (p_pin) else $error("cache off pin wrong"); // RQ20

   property p_wt_pin;
      @(posedge sys_clk) disable iff (rst)
      bus_cycle && bus_unpaged && mc_q[pcfd_pkg::MC_PAGING_ENABLE]
      |=> write_thru_pin_q == $past(pb_q[pcfd_pkg::PB_PAGE_LEVEL_WRITE_THRU]);
   endproperty
   a_wt_pin: assert property (p_wt_pin) else $error("write through pin wrong"); // RQ21

   property p_rsvd;
      @(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == 4'h8 |=> reg_rdata[31:11] == 21'h000000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // RQ23

   c_stall: cover property (@(posedge sys_clk) disable iff (rst) fp_stall ##1 fpu_done);
   c_trap: cover property (@(posedge sys_clk) disable iff (rst) dev_not_avail_q);
   c_pin: cover property (@(posedge sys_clk) disable iff (rst) write_thru_pin_q);
endmodule

// ===== rtl/pcfd_pkg.sv
// Constants for the processor control flag decode block.
// Assumes a single core clock and a plain one-cycle register port.
package pcfd_pkg;
   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [3:0] ADDR_MACHINE_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_PAGE_BASE_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_EXTENSION_CONTROL = 4'h8;
   localparam logic [3:0] ADDR_STATUS            = 4'hc;
   // ****************************************************************
   // Machine control fields
   // ****************************************************************
   localparam int MC_WAIT_TEST_SWITCH_ENABLE = 1;
   localparam int MC_SOFTWARE_FP_TRAP        = 2;
   localparam int MC_FPU_CTX_SWITCHED        = 3;
   localparam int MC_NUMERIC_ERROR_REPORT    = 5;
   localparam int MC_WRITE_PROTECT           = 16;
   localparam int MC_ALIGNMENT_GATE          = 18;
   localparam int MC_NO_WRITE_THROUGH        = 29;
   localparam int MC_CACHE_OFF               = 30;
   localparam int MC_PAGING_ENABLE           = 31;
   localparam logic [31:0] MC_WRITE_MASK     = 32'he005_002e;
   localparam logic [31:0] MC_RESET          = 32'h0000_0000;
   // ****************************************************************
   // Page base control fields
   // ****************************************************************
   localparam int PB_PAGE_LEVEL_WRITE_THRU   = 3;
   localparam int PB_PAGE_LEVEL_CACHE_OFF    = 4;
   localparam logic [31:0] PB_WRITE_MASK     = 32'hffff_f018;
   localparam logic [31:0] PB_RESET          = 32'h0000_0000;
   // ****************************************************************
   // Extension control fields
   // ****************************************************************
   localparam int EC_V86_EXTENSIONS          = 0;
   localparam int EC_PROTECTED_VIRTUAL_IRQ   = 1;
   localparam int EC_TIMESTAMP_RESTRICT      = 2;
   localparam int EC_DBG_EXTENSIONS          = 3;
   localparam int EC_LARGE_PAGE_ENABLE       = 4;
   localparam int EC_PHYS_ADDR_EXTENSION     = 5;
   localparam int EC_MACHINE_CHECK_ENABLE    = 6;
   localparam int EC_GLOBAL_PAGE_ENABLE      = 7;
   localparam int EC_PERF_COUNTER_USER_EN    = 8;
   localparam int EC_FP_STATE_SAVE_SUPPORT   = 9;
   localparam int EC_SIMD_FP_EXC_SUPPORT     = 10;
   localparam logic [31:0] EC_WRITE_MASK     = 32'h0000_07ff;
   localparam logic [31:0] EC_RESET          = 32'h0000_0000;
   // ****************************************************************
   // Status fields and fixed values
   // ****************************************************************
   localparam int ST_FP_BUSY                 = 0;
   localparam logic [15:0] FP_CW_ABSENT      = 16'hffff;
   localparam logic [15:0] FP_CW_PRESENT     = 16'h037f;
   localparam logic [7:0]  DEV_NOT_AVAIL_VEC = 8'h07;
   localparam logic [1:0]  CPL_KERNEL        = 2'h0;
   localparam logic [2:0]  DBG_IDX_FOUR      = 3'h4;
   localparam logic [2:0]  DBG_IDX_FIVE      = 3'h5;
   localparam logic [2:0]  DBG_ALIAS_OFFSET  = 3'h2;
endpackage

// ===== sim/pcfd_cache_model.sv
// External cache model that follows the page attribute pins.
// Assumes the pins are valid in the cycle after a bus cycle is taken.
`timescale 1ns/1ps
module pcfd_cache_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic bus_cycle,
   input  wire logic cache_off_pin_q,
   input  wire logic write_thru_pin_q,
   output logic      cached_q,
   output logic      wt_q
);
   // ***************
   // Cycle policy
   // ***************
   logic bus_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_q    <= 1'b0;
         cached_q <= 1'b0;
         wt_q     <= 1'b0;
      end else begin
         bus_q <= bus_cycle;
         if (bus_q) begin
            cached_q <= !cache_off_pin_q;
            wt_q     <= write_thru_pin_q;
         end
      end
   end
endmodule

// ===== sim/processor_control_flag_decode_test.sv
// Self-checking bench for the control flag decode block.
// Assumes a 20 MHz clock and the one-cycle register port.
`timescale 1ns/1ps
module processor_control_flag_decode_test;
   typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} pcfd_row_type;
   logic        sys_clk, rst, reg_wr, reg_rd, fpu_present, align_check_flag;
   logic        bus_cycle, bus_unpaged, pte_cache_off, pte_write_thru;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r;
   logic [1:0]  cpl;
   logic [2:0]  dbg_idx, dbg_idx_eff_q;
   logic [8:0]  ev;
   logic [7:0]  exc_vector_q;
   logic [15:0] fp_ctrl_word_q;
   logic fp_stall, fp_dispatch_q, dev_not_avail_q, wait_done_q, fp_err_internal_q;
   logic fp_err_external_q, perf_read_ok_q, timestamp_read_ok_q, priv_fault_q;
   logic undefined_opcode_fault_q, machine_check_q, tlb_flush_q, tlb_keep_global_q;
   logic phys_addr_wide, large_page_en, v86_virq_en, pm_virq_en, simd_fp_exception_support;
   logic fp_state_save_support, sup_write_protect, align_check_active, cache_en;
   logic wt_inval_en, cache_off_pin_q, write_thru_pin_q, cached_q, wt_q;
   int   fail_count, cmp_count, cyc;
   pcfd_row_type rows [5] = '{'{4'h0, 32'hffff_ffff, 32'he005_002e},
      '{4'h4, 32'hffff_ffff, 32'hffff_f018}, '{4'h2, 32'hffff_ffff, 32'h0},
      '{4'h8, 32'hffff_ffff, 32'h0000_07ff}, '{4'hc, 32'hffff_ffff, 32'hffff_0000}};

   pcfd_ctrl_flags DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cpl, .fp_issue(ev[7]), .fpu_done(ev[8]), .fpu_present, .fp_wait_instr(ev[6]),
      .fp_init_instr(ev[5]), .fp_numeric_err(ev[4]), .read_perf_counter_instr(ev[3]),
      .read_timestamp_instr(ev[2]), .dbg_access(ev[1]), .dbg_idx, .hw_error(ev[0]),
      .align_check_flag, .bus_cycle, .bus_unpaged, .pte_cache_off, .pte_write_thru,
      .fp_stall, .fp_dispatch_q, .dev_not_avail_q, .exc_vector_q, .wait_done_q,
      .fp_ctrl_word_q, .fp_err_internal_q, .fp_err_external_q, .perf_read_ok_q,
      .timestamp_read_ok_q, .priv_fault_q, .undefined_opcode_fault_q, .dbg_idx_eff_q,
      .machine_check_q, .tlb_flush_q, .tlb_keep_global_q, .phys_addr_wide, .large_page_en,
      .v86_virq_en, .pm_virq_en, .simd_fp_exception_support, .fp_state_save_support,
      .sup_write_protect, .align_check_active, .cache_en, .wt_inval_en, .cache_off_pin_q,
      .write_thru_pin_q);
   pcfd_cache_model cache (.sys_clk, .rst, .bus_cycle, .cache_off_pin_q,
      .write_thru_pin_q, .cached_q, .wt_q);

   // ***************
   // Tasks
   // ***************
   task finish_test;
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task evt(input logic [8:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 9'h000;
      #1;
   endtask
   task bus(input logic u, input logic [1:0] pte, input logic [1:0] pins, input logic [1:0] seen);
      @(posedge sys_clk);
      bus_cycle <= 1'b1;
      bus_unpaged <= u;
      {pte_cache_off, pte_write_thru} <= pte;
      @(posedge sys_clk);
      bus_cycle <= 1'b0;
      #1 chk({cache_off_pin_q, write_thru_pin_q}, pins);
      @(posedge sys_clk);
      #1 chk({cached_q, wt_q}, seen);
   endtask

   // ***************
   // Stimulus
   // ***************
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         finish_test;
      end
   end
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, ev, align_check_flag} = '0;
      {bus_cycle, bus_unpaged, pte_cache_off, pte_write_thru} = 4'h0;
      {fpu_present, cpl, dbg_idx} = {1'b1, 2'h3, 3'h4};
      {fail_count, cmp_count, cyc} = '0;
      rst = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h8, r);
      chk(r, 32'h0);
      chk({cache_en, wt_inval_en, fp_ctrl_word_q}, {2'b11, 16'hffff});
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, r);
         chk(r, rows[i].e);
      end
      chk({sup_write_protect, align_check_active, cache_en, wt_inval_en}, 4'h8);
      @(posedge sys_clk);
      align_check_flag <= 1'b1;
      #1 chk(align_check_active, 1'b1);
      chk({phys_addr_wide, large_page_en, v86_virq_en, pm_virq_en}, 4'hf);
      chk({simd_fp_exception_support, fp_state_save_support}, 2'b11);
      evt(9'h004);
      chk({timestamp_read_ok_q, priv_fault_q}, 2'b01);
      evt(9'h008);
      chk({perf_read_ok_q, priv_fault_q}, 2'b10);
      evt(9'h002);
      chk(undefined_opcode_fault_q, 1'b1);
      evt(9'h001);
      chk(machine_check_q, 1'b1);
      @(posedge sys_clk);
      cpl <= 2'h0;
      evt(9'h004);
      chk({timestamp_read_ok_q, priv_fault_q}, 2'b10);
      @(posedge sys_clk);
      cpl <= 2'h3;
      wr(4'h4, 32'h0);
      chk(tlb_keep_global_q, 1'b1);
      wr(4'h8, 32'h0);
      chk({phys_addr_wide, large_page_en, v86_virq_en, pm_virq_en}, 4'h0);
      chk({simd_fp_exception_support, fp_state_save_support}, 2'b00);
      evt(9'h004);
      chk({timestamp_read_ok_q, priv_fault_q}, 2'b10);
      evt(9'h008);
      chk({perf_read_ok_q, priv_fault_q}, 2'b01);
      evt(9'h002);
      chk({undefined_opcode_fault_q, dbg_idx_eff_q}, 4'h6);
      evt(9'h001);
      chk(machine_check_q, 1'b0);
      wr(4'h4, 32'h0);
      chk({tlb_flush_q, tlb_keep_global_q}, 2'b10);
      wr(4'h0, 32'h0);
      evt(9'h080);
      chk(fp_dispatch_q, 1'b1);
      @(posedge sys_clk);
      ev <= 9'h080;
      #1 chk({fp_stall, fp_dispatch_q}, 2'b10);
      @(posedge sys_clk);
      ev <= 9'h180;
      @(posedge sys_clk);
      ev <= 9'h080;
      #1 chk({fp_stall, fp_dispatch_q}, 2'b00);
      @(posedge sys_clk);
      ev <= 9'h000;
      #1 chk(fp_dispatch_q, 1'b1);
      evt(9'h100);
      evt(9'h020);
      chk(fp_ctrl_word_q, 16'h037f);
      @(posedge sys_clk);
      fpu_present <= 1'b0;
      evt(9'h020);
      chk(fp_ctrl_word_q, 16'hffff);
      wr(4'h0, 32'h4);
      evt(9'h080);
      chk({dev_not_avail_q, fp_dispatch_q, exc_vector_q}, {2'b10, 8'h07});
      wr(4'h0, 32'h8);
      evt(9'h040);
      chk({wait_done_q, dev_not_avail_q}, 2'b10);
      wr(4'h0, 32'ha);
      evt(9'h040);
      chk({wait_done_q, dev_not_avail_q}, 2'b01);
      wr(4'h0, 32'h20);
      evt(9'h010);
      chk({fp_err_internal_q, fp_err_external_q}, 2'b10);
      wr(4'h0, 32'h8000_0000);
      evt(9'h010);
      chk({fp_err_internal_q, fp_err_external_q}, 2'b01);
      wr(4'h4, 32'h0000_0018);
      bus(1'b1, 2'b00, 2'b11, 2'b01);
      bus(1'b0, 2'b10, 2'b10, 2'b00);
      wr(4'h0, 32'h0);
      bus(1'b1, 2'b00, 2'b00, 2'b10);
      wr(4'h8, 32'hffff_ffff);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h8, r);
      chk(r, 32'h0);
      chk({phys_addr_wide, cache_en}, 2'b01);
      finish_test;
   end
endmodule
